// ---- rtl/pin_sync.sv ----
// Three-flop synchroniser with agreement filter and edge pulses.
// Assumes a synchronous active-high reset on the system clock.
`timescale 1ns/1ns
module pin_sync #(
  parameter logic RESET_LEVEL = 1'b0
) (
  input  wire logic clock_i,
  input  wire logic rst_i,
  pin_sync_if.sync  pin
);

  logic stage1_reg;
  logic stage2_reg;
  logic stage3_reg;
  logic level_reg;
  logic rise_reg;
  logic fall_reg;

  // Shift chain; the first stage feeds only the second
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      stage1_reg <= RESET_LEVEL;
      stage2_reg <= RESET_LEVEL;
      stage3_reg <= RESET_LEVEL;
    end else begin
      stage1_reg <= pin.raw;
      stage2_reg <= stage1_reg;
      stage3_reg <= stage2_reg;
    end
  end

  // Accept a change only once stages two and three agree, masking glitches
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      level_reg <= RESET_LEVEL;
      rise_reg  <= 1'b0;
      fall_reg  <= 1'b0;
    end else begin
      rise_reg <= 1'b0;
      fall_reg <= 1'b0;
      if (stage2_reg == stage3_reg && stage3_reg != level_reg) begin
        level_reg <= stage3_reg;
        rise_reg  <= stage3_reg;
        fall_reg  <= ~stage3_reg;
      end
    end
  end

  assign pin.level = level_reg;
  assign pin.rise  = rise_reg;
  assign pin.fall  = fall_reg;

endmodule : pin_sync

// ---- rtl/pin_sync_if.sv ----
// Interface carrying one pin through its synchroniser.
// Assumes the raw level comes from outside the system clock domain.
`timescale 1ns/1ns
interface pin_sync_if;
  logic raw;    // Pin level as it arrives
  logic level;  // Filtered level in the clock domain
  logic rise;   // One-cycle pulse on a filtered rising change
  logic fall;   // One-cycle pulse on a filtered falling change

  modport sync (input raw, output level, output rise, output fall);
  modport user (output raw, input level, input rise, input fall);
endinterface : pin_sync_if

// ---- rtl/receiver_status_readout.sv ----
// Status registers of the packet receiver, read over the serial register port.
// Assumes status inputs come from logic on clock_i; port pins are asynchronous
// and the serial clock is well below a quarter of the system clock.
`timescale 1ns/1ns

module receiver_status_readout (
  input  wire logic                                   clock_i,
  input  wire logic                                   rst_i,
  input  wire logic                                   port_select_n_i,
  input  wire logic                                   port_clock_i,
  input  wire logic                                   port_data_i,
  output logic                                        port_data_o,
  output logic                                        port_data_oe_o,
  input  wire logic [status_readout_pkg::STATE_W-1:0] radio_state_code_i,
  input  wire logic                                   crc_check_done_i,
  input  wire logic                                   crc_check_pass_i,
  input  wire logic                                   carrier_sense_i,
  input  wire logic                                   sync_found_i,
  input  wire logic                                   packet_end_i,
  input  wire logic                                   packet_drop_i,
  input  wire logic                                   output_pin_b_level_i,
  input  wire logic                                   output_pin_a_level_i,
  input  wire logic                                   rx_queue_overflow_i,
  input  wire logic [status_readout_pkg::RQ_LEVEL_W-1:0] rx_queue_level_i
);

  pin_sync_if select_pin ();
  pin_sync_if clock_pin ();
  pin_sync_if data_pin ();

  status_readout_pkg::radio_state_code_t state_reg;
  status_readout_pkg::radio_state_code_t state_next;
  status_readout_pkg::port_state_t       port_state_reg;
  logic                                  crc_ok_reg;
  logic                                  carrier_reg;
  logic                                  frame_start_reg;
  logic                                  pin_b_reg;
  logic                                  pin_a_reg;
  logic                                  overflow_reg;
  logic [status_readout_pkg::RQ_LEVEL_W-1:0] level_reg;
  logic [7:0]                            header_reg;
  logic [7:0]                            tx_reg;
  logic [2:0]                            bit_count_reg;
  logic                                  data_out_reg;
  logic                                  data_oe_reg;
  logic                                  rx_entry;
  logic                                  header_last;
  logic [7:0]                            header_full;
  logic [7:0]                            read_value;
  logic [7:0]                            state_byte;
  logic [7:0]                            status_byte;
  logic [7:0]                            count_byte;

  // Port pins pass the three-flop filter before any use
  assign select_pin.raw = port_select_n_i;
  assign clock_pin.raw  = port_clock_i;
  assign data_pin.raw   = port_data_i;

  pin_sync #(.RESET_LEVEL(1'b1)) select_sync (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .pin     (select_pin)
  );

  pin_sync #(.RESET_LEVEL(1'b0)) clock_sync (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .pin     (clock_pin)
  );

  pin_sync #(.RESET_LEVEL(1'b0)) data_sync (
    .clock_i (clock_i),
    .rst_i   (rst_i),
    .pin     (data_pin)
  );

  // Map the incoming code; a reserved code holds the last valid one
  always_comb begin
    unique case (radio_state_code_i)
      5'h00, 5'h01, 5'h02: state_next =
        status_readout_pkg::radio_state_code_t'(radio_state_code_i);
      5'h03, 5'h04, 5'h05: state_next =
        status_readout_pkg::radio_state_code_t'(radio_state_code_i);
      5'h06, 5'h07, 5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C: state_next =
        status_readout_pkg::radio_state_code_t'(radio_state_code_i);
      5'h0D, 5'h0E, 5'h0F: state_next =
        status_readout_pkg::radio_state_code_t'(radio_state_code_i);
      5'h11:   state_next = status_readout_pkg::RX_OVERFLOW_CODE;
      default: state_next = state_reg;
    endcase
  end

  // Live state code register
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_reg <= status_readout_pkg::SLEEP_CODE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Entering receive from elsewhere, or restarting it, clears the CRC match
  assign rx_entry = (state_next == status_readout_pkg::RX_CODE &&
                     state_reg != status_readout_pkg::RX_CODE) ||
                    (state_next == status_readout_pkg::RX_RESTART_CODE &&
                     state_reg != status_readout_pkg::RX_RESTART_CODE);

  // CRC match flag; a check result in the clearing cycle wins
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      crc_ok_reg <= 1'b0;
    end else if (crc_check_done_i) begin
      crc_ok_reg <= crc_check_pass_i;
    end else if (rx_entry) begin
      crc_ok_reg <= 1'b0;
    end
  end

  // Carrier sense follows its source but is forced low in idle
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      carrier_reg <= 1'b0;
    end else begin
      carrier_reg <= carrier_sense_i &&
                     (state_next != status_readout_pkg::IDLE_CODE);
    end
  end

  // Frame start flag; a new sync beats a simultaneous end or drop
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      frame_start_reg <= 1'b0;
    end else if (sync_found_i) begin
      frame_start_reg <= 1'b1;
    end else if (packet_end_i) begin
      frame_start_reg <= 1'b0;
    end else if (packet_drop_i ||
                 state_next == status_readout_pkg::RX_OVERFLOW_CODE) begin
      frame_start_reg <= 1'b0;
    end
  end

  // Pin levels are taken before the output inverter, so invert settings never apply
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      pin_b_reg <= 1'b0;
      pin_a_reg <= 1'b0;
    end else begin
      pin_b_reg <= output_pin_b_level_i;
      pin_a_reg <= output_pin_a_level_i;
    end
  end

  // Queue occupancy and overflow
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      overflow_reg <= 1'b0;
      level_reg    <= '0;
    end else begin
      overflow_reg <= rx_queue_overflow_i;
      level_reg    <= rx_queue_level_i;
    end
  end

  // Register images; unused bits are constant zero
  assign state_byte = {3'h0, state_reg};
  always_comb begin
    status_byte = 8'h00;
    status_byte[status_readout_pkg::PS_CRC_OK_BIT]  = crc_ok_reg;
    status_byte[status_readout_pkg::PS_CARRIER_BIT] = carrier_reg;
    status_byte[status_readout_pkg::PS_FRAME_BIT]   = frame_start_reg;
    status_byte[status_readout_pkg::PS_PIN_B_BIT]   = pin_b_reg;
    status_byte[status_readout_pkg::PS_PIN_A_BIT]   = pin_a_reg;
  end
  assign count_byte = {overflow_reg, level_reg};

  // Header as it stands after the current serial clock edge
  assign header_full = {header_reg[6:0], data_pin.level};
  assign header_last = bit_count_reg == status_readout_pkg::BIT_COUNT_LAST;

  // Decode: only burst reads of the three status offsets return data
  always_comb begin
    read_value = status_readout_pkg::READ_NONE_VALUE;
    if (header_full[status_readout_pkg::HDR_READ_BIT] &&
        header_full[status_readout_pkg::HDR_BURST_BIT]) begin
      unique case (header_full[status_readout_pkg::HDR_ADDR_MSB:0])
        status_readout_pkg::RADIO_STATE_ADDR: read_value = state_byte;
        status_readout_pkg::PKT_STATUS_ADDR:  read_value = status_byte;
        status_readout_pkg::RX_QUEUE_ADDR:    read_value = count_byte;
        default:                              read_value = status_readout_pkg::READ_NONE_VALUE;
      endcase
    end
  end

  // Serial port sequencer; header in on rising clock, data out on falling
  always_ff @(posedge clock_i) begin
    if (rst_i || select_pin.level) begin
      port_state_reg <= status_readout_pkg::PORT_WAIT;
      bit_count_reg  <= 3'h0;
      header_reg     <= 8'h00;
      tx_reg         <= 8'h00;
    end else begin
      unique case (port_state_reg)
        status_readout_pkg::PORT_WAIT: begin
          port_state_reg <= status_readout_pkg::PORT_HEADER;
        end
        status_readout_pkg::PORT_HEADER: begin
          if (clock_pin.rise) begin
            header_reg    <= header_full;
            bit_count_reg <= bit_count_reg + 3'h1;
            if (header_last) begin
              tx_reg         <= read_value;
              port_state_reg <= status_readout_pkg::PORT_DATA;
            end
          end
        end
        status_readout_pkg::PORT_DATA: begin
          // The fall that closes the last header bit must not shift: the MSB
          // has to stand until the host samples it on the first data rise
          if (clock_pin.fall && bit_count_reg != 3'h0) begin
            tx_reg <= {tx_reg[6:0], 1'b0};
          end
          if (clock_pin.rise) begin
            bit_count_reg <= bit_count_reg + 3'h1;
            if (header_last) begin
              port_state_reg <= status_readout_pkg::PORT_DONE;
            end
          end
        end
        status_readout_pkg::PORT_DONE: begin
          port_state_reg <= status_readout_pkg::PORT_DONE; // Writes and bursts ignored
        end
      endcase
    end
  end

  // Output pin: driven while selected; zeros outside the data byte
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      data_out_reg <= 1'b0;
      data_oe_reg  <= 1'b0;
    end else begin
      data_oe_reg  <= ~select_pin.level;
      data_out_reg <= (port_state_reg == status_readout_pkg::PORT_DATA) ? tx_reg[7] : 1'b0;
    end
  end

  assign port_data_o    = data_out_reg;
  assign port_data_oe_o = data_oe_reg;

  // Checks
  crc_clear_a: assert property (@(posedge clock_i) disable iff (rst_i)
    rx_entry && !crc_check_done_i |=> !crc_ok_reg)
    else $error("CRC match not cleared on receive entry");

  crc_set_a: assert property (@(posedge clock_i) disable iff (rst_i)
    crc_check_done_i && crc_check_pass_i |=> crc_ok_reg)
    else $error("CRC match not set after passing check");

  carrier_idle_a: assert property (@(posedge clock_i) disable iff (rst_i)
    radio_state_code_i == 5'h01 |=> !carrier_reg)
    else $error("Carrier sense set in idle");

  frame_set_a: assert property (@(posedge clock_i) disable iff (rst_i)
    sync_found_i |=> frame_start_reg ##1 (frame_start_reg || $past(packet_end_i) ||
    $past(packet_drop_i) || state_reg == status_readout_pkg::RX_OVERFLOW_CODE))
    else $error("Frame start not raised on sync");

  frame_drop_a: assert property (@(posedge clock_i) disable iff (rst_i)
    !sync_found_i && (packet_drop_i || radio_state_code_i == 5'h11) |=> !frame_start_reg)
    else $error("Frame start not dropped");

  state_valid_a: assert property (@(posedge clock_i) disable iff (rst_i)
    state_reg != 5'h10 && state_reg <= 5'h11)
    else $error("Reserved radio state reported");

  pin_level_a: assert property (@(posedge clock_i) disable iff (rst_i)
    ##1 status_byte[2] == $past(output_pin_b_level_i) && status_byte[0] == $past(output_pin_a_level_i))
    else $error("Pin level bits do not follow internal levels");

  queue_count_a: assert property (@(posedge clock_i) disable iff (rst_i)
    ##1 count_byte == {$past(rx_queue_overflow_i), $past(rx_queue_level_i)})
    else $error("Queue count does not follow queue");

  unused_zero_a: assert property (@(posedge clock_i) disable iff (rst_i)
    status_byte[1] == 1'b0 && status_byte[5:4] == 2'h0 && state_byte[7:5] == 3'h0)
    else $error("Unused status bit not zero");

endmodule : receiver_status_readout

// ---- rtl/status_readout_pkg.sv ----
// Package of constants for the receiver status readout block.
// Assumes a 20 MHz system clock and a four-wire serial register port.
package status_readout_pkg;

  // Register offsets on the serial register port
  localparam logic [5:0] RADIO_STATE_ADDR  = 6'h35;
  localparam logic [5:0] PKT_STATUS_ADDR   = 6'h38;
  localparam logic [5:0] RX_QUEUE_ADDR     = 6'h3B;

  // Header byte layout: read flag, burst flag, address
  localparam int unsigned HDR_READ_BIT  = 7;
  localparam int unsigned HDR_BURST_BIT = 6;
  localparam int unsigned HDR_ADDR_MSB  = 5;

  // Packet status bit positions
  localparam int unsigned PS_CRC_OK_BIT  = 7;
  localparam int unsigned PS_CARRIER_BIT = 6;
  localparam int unsigned PS_FRAME_BIT   = 3;
  localparam int unsigned PS_PIN_B_BIT   = 2;
  localparam int unsigned PS_PIN_A_BIT   = 0;

  // Queue count layout
  localparam int unsigned RQ_OVERFLOW_BIT = 7;
  localparam int unsigned RQ_LEVEL_W      = 7;

  // Width of the radio state code
  localparam int unsigned STATE_W = 5;

  // Refused-read value and last bit count
  localparam logic [7:0] READ_NONE_VALUE = 8'h00;
  localparam logic [2:0] BIT_COUNT_LAST  = 3'h7;

  // Radio control state codes as reported to the host
  typedef enum logic [4:0] {
    SLEEP_CODE        = 5'h00,
    IDLE_CODE         = 5'h01,
    CRYSTAL_OFF_CODE  = 5'h02,
    MC_OSC_ON_CODE    = 5'h03,
    MC_REG_ON_CODE    = 5'h04,
    MANUAL_CAL_CODE   = 5'h05,
    WAKE_OSC_ON_CODE  = 5'h06,
    WAKE_REG_ON_CODE  = 5'h07,
    CAL_START_CODE    = 5'h08,
    BW_BOOST_CODE     = 5'h09,
    SYNTH_LOCK_CODE   = 5'h0A,
    IF_CONV_ON_CODE   = 5'h0B,
    CAL_END_CODE      = 5'h0C,
    RX_CODE           = 5'h0D,
    RX_END_CODE       = 5'h0E,
    RX_RESTART_CODE   = 5'h0F,
    RX_OVERFLOW_CODE  = 5'h11
  } radio_state_code_t;

  // Serial port sequencer, Gray coded along wait, header, data, done
  typedef enum logic [1:0] {
    PORT_WAIT   = 2'h0,
    PORT_HEADER = 2'h1,
    PORT_DATA   = 2'h3,
    PORT_DONE   = 2'h2
  } port_state_t;

endpackage : status_readout_pkg

// ---- tb/host_port_model.sv ----
// Host side of the serial register port: drives select, serial clock and data in.
// Assumes the bench clock and that the device drives its data line only when enabled.
`timescale 1ns/1ns
module host_port_model (
  input  wire logic clock_i,
  output logic      select_n_o,
  output logic      sclk_o,
  output logic      mosi_o,
  input  wire logic miso_i,
  input  wire logic miso_oe_i
);
  // Phases kept well above the two-clock minimum of the device filter
  localparam int HALF = 8;
  logic last_bit = 1'b0;
  logic line;

  // A released line shows the inverse of its last value, never a friendly 0
  assign line = miso_oe_i ? miso_i : ~last_bit;

  // Remember what the device last drove
  always @(posedge clock_i) begin
    if (miso_oe_i) begin
      last_bit <= miso_i;
    end
  end

  initial begin
    select_n_o = 1'b1;
    sclk_o     = 1'b0;
    mosi_o     = 1'b0;
  end

  // One whole access: header then one data byte, MSB first, clock idles low
  // Lock status is never polled through the pin level bits
  task automatic xfer(input logic [7:0] hdr, input logic [7:0] wr, output logic [7:0] rd);
    logic [15:0] bits;
    bits = {hdr, wr};
    rd = 8'h00;
    @(posedge clock_i) select_n_o <= 1'b0;
    repeat (HALF) @(posedge clock_i);
    for (int i = 15; i >= 0; i--) begin
      mosi_o <= bits[i];
      repeat (HALF) @(posedge clock_i);
      sclk_o <= 1'b1;
      if (i < 8) begin
        rd[i] = line;
      end
      repeat (HALF) @(posedge clock_i);
      sclk_o <= 1'b0;
    end
    repeat (HALF) @(posedge clock_i);
    select_n_o <= 1'b1;
    repeat (HALF) @(posedge clock_i);
  endtask : xfer
endmodule : host_port_model

// ---- tb/tb_receiver_status_readout.sv ----
// Self-checking bench for the receiver status readout registers.
// Assumes the host model above and status inputs driven on clock_i.
`timescale 1ns/1ns
module tb_receiver_status_readout;
  logic       clock_i;
  logic       rst_i;
  logic       sel_n;
  logic       sclk;
  logic       mosi;
  logic       miso;
  logic       miso_oe;
  logic [4:0] state_code;
  logic       crc_done;
  logic       crc_pass;
  logic       carrier;
  logic       sync_found;
  logic       pkt_end;
  logic       pkt_drop;
  logic       pin_b;
  logic       pin_a;
  logic       q_ovf;
  logic [6:0] q_level;
  int         fails = 0;
  int         checks_done = 0;
  logic [4:0] codes [17] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08,
                             5'h09, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0E, 5'h0F, 5'h11};
  logic [7:0] queue [4] = '{8'h00, 8'h7F, 8'h80, 8'hC1};

  receiver_status_readout i_receiver_status_readout (
    .clock_i(clock_i), .rst_i(rst_i), .port_select_n_i(sel_n), .port_clock_i(sclk),
    .port_data_i(mosi), .port_data_o(miso), .port_data_oe_o(miso_oe),
    .radio_state_code_i(state_code), .crc_check_done_i(crc_done),
    .crc_check_pass_i(crc_pass), .carrier_sense_i(carrier), .sync_found_i(sync_found),
    .packet_end_i(pkt_end), .packet_drop_i(pkt_drop), .output_pin_b_level_i(pin_b),
    .output_pin_a_level_i(pin_a), .rx_queue_overflow_i(q_ovf), .rx_queue_level_i(q_level));

  host_port_model i_host_port_model (
    .clock_i(clock_i), .select_n_o(sel_n), .sclk_o(sclk), .mosi_o(mosi),
    .miso_i(miso), .miso_oe_i(miso_oe));

  // Free-running system clock
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end

  task automatic summarize();
    if (fails == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : summarize

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Full access, then the released port must sit quiet
  task automatic rd_check(input logic [7:0] hdr, input logic [7:0] exp);
    logic [7:0] got;
    repeat (2) @(posedge clock_i);
    i_host_port_model.xfer(hdr, 8'hFF, got);
    check(got, exp);
    check({6'h00, miso_oe, miso}, 8'h00);
  endtask : rd_check

  task automatic set_state(input logic [4:0] code);
    @(posedge clock_i) state_code <= code;
  endtask : set_state

  // One-cycle event pulse: 0 sync, 1 end, 2 drop, else CRC done
  task automatic pulse(input int sel);
    @(posedge clock_i);
    case (sel)
      0: sync_found <= 1'b1;
      1: pkt_end <= 1'b1;
      2: pkt_drop <= 1'b1;
      default: crc_done <= 1'b1;
    endcase
    @(posedge clock_i);
    {sync_found, pkt_end, pkt_drop, crc_done} <= 4'h0;
  endtask : pulse

  // Hang guard: the whole run is far shorter than this
  initial begin
    repeat (100000) @(posedge clock_i);
    fails++;
    summarize();
  end

  initial begin
    rst_i = 1'b1;
    state_code = 5'h00;
    {crc_done, crc_pass, carrier, sync_found, pkt_end, pkt_drop} = 6'h10;
    {pin_b, pin_a, q_ovf, q_level} = 10'h000;
    repeat (3) @(posedge clock_i);
    rst_i <= 1'b0;
    repeat (8) @(posedge clock_i);
    // Every valid state code, then reserved codes hold the last valid one
    for (int k = 0; k < 17; k++) begin
      set_state(codes[k]);
      rd_check(8'hF5, {3'h0, codes[k]});
    end
    set_state(5'h10);
    rd_check(8'hF5, 8'h11);
    set_state(5'h16);
    rd_check(8'hF5, 8'h11);
    // Carrier is masked in idle, shown in receive
    @(posedge clock_i) carrier <= 1'b1;
    set_state(5'h01);
    rd_check(8'hF8, 8'h00);
    set_state(5'h0D);
    rd_check(8'hF8, 8'h40);
    pulse(3);
    rd_check(8'hF8, 8'hC0);
    pulse(0);
    rd_check(8'hF8, 8'hC8);
    pulse(1);
    rd_check(8'hF8, 8'hC0);
    pulse(0);
    pulse(2);
    rd_check(8'hF8, 8'hC0);
    pulse(0);
    set_state(5'h11);
    rd_check(8'hF8, 8'hC0);
    set_state(5'h0F);
    rd_check(8'hF8, 8'h40);
    pulse(3);
    set_state(5'h0E);
    set_state(5'h0D);
    rd_check(8'hF8, 8'h40);
    for (int j = 0; j < 4; j++) begin
      @(posedge clock_i) {pin_b, pin_a} <= j[1:0];
      rd_check(8'hF8, {5'h08, j[1], 1'b0, j[0]});
    end
    for (int q = 0; q < 4; q++) begin
      @(posedge clock_i) {q_ovf, q_level} <= queue[q];
      rd_check(8'hFB, queue[q]);
    end
    // Write, single read and unmapped offset are all refused
    rd_check(8'h78, 8'h00);
    rd_check(8'hB8, 8'h00);
    rd_check(8'hF0, 8'h00);
    rd_check(8'hF8, 8'h45);
    summarize();
  end
endmodule : tb_receiver_status_readout
